// >>> hdl/acs_pkg.sv
// Shared constants, types and helpers for the converter compare sequencer.
package acs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus.
    localparam int ACS_AW = 8;
    localparam int ACS_DW = 8;
    localparam logic [ACS_AW-1:0] ACS_CHAN_SEL_OFS = 8'h24;
    localparam logic [ACS_AW-1:0] ACS_MODE_SEL_OFS = 8'h25;
    localparam logic [ACS_AW-1:0] ACS_REF_VAL_OFS = 8'h26;
    localparam logic [ACS_AW-1:0] ACS_PULLDOWN_OFS = 8'h27;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions of the mode selection register.
    localparam int ACS_BIT_RESULT = 0;
    localparam int ACS_BIT_STATUS = 1;
    localparam int ACS_BIT_MODE = 2;
    localparam int ACS_BIT_ZERO = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Widths, reset values and codes.
    localparam int ACS_NUM_AIN = 6;
    localparam int ACS_NUM_PD = 4;
    localparam int ACS_NUM_TAPS = 256;
    localparam logic [2:0] ACS_CHAN_NONE = 3'h0;
    localparam logic [2:0] ACS_CHAN_BAD = 3'h7;
    localparam logic [ACS_NUM_PD-1:0] ACS_PULLDOWN_RESET = 4'hf;
    localparam logic [7:0] ACS_REF_RESET = 8'h00;
    localparam logic [7:0] ACS_SAR_SEED = 8'h80;
    localparam logic [ACS_NUM_TAPS-1:0] ACS_TAP_ONE = 256'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Timing in instruction cycles.
    localparam logic [4:0] ACS_SW_DONE_TICKS = 5'h03;
    localparam logic [4:0] ACS_HW_BUSY_TICKS = 5'h0f;
    localparam logic [4:0] ACS_HW_DONE_TICKS = 5'h11;
    localparam logic [4:0] ACS_HW_FIRST_STEP = 5'h03;

    ////////////////////////////////////////////////////////////////////////////
    // Types.
    typedef enum logic [2:0] {
        ACS_IDLE = 3'b001,
        ACS_SW_WAIT = 3'b010,
        ACS_HW_RUN = 3'b100
    } acs_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ACS_AW-1:0] addr;
        logic [ACS_DW-1:0] wdata;
    } acs_bus_req_t;

    typedef struct packed {
        logic wdt_stack;
        logic ce;
        logic clk_stop;
    } acs_reset_evt_t;

    // Channel code to one-hot pin select; codes 0 and 7 select nothing.
    function automatic logic [ACS_NUM_AIN-1:0] acs_chan_onehot(input logic [2:0] ch);
        logic [ACS_NUM_AIN-1:0] sel;
        sel = '0;
        if (ch != ACS_CHAN_NONE && ch != ACS_CHAN_BAD)
        begin
            sel[ch - 3'h1] = 1'b1;
        end
        return sel;
    endfunction

endpackage

// >>> hdl/acs_tap_decoder.sv
// Registered one-of-256 tap decoder for the resistor-string reference.
`timescale 1ns/1ps
`default_nettype none

module acs_tap_decoder
    import acs_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_sync_n,
    // Reference code and the tap it selects.
    input wire logic [7:0] ref_value,
    output logic [ACS_NUM_TAPS-1:0] tap_sel
);

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            tap_sel <= ACS_TAP_ONE;
        else
            tap_sel <= ACS_TAP_ONE << ref_value;
    end

    chk_tap_onehot: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        ##1 (tap_sel == (ACS_TAP_ONE << $past(ref_value))) && $onehot(tap_sel))
        else $error("tap select does not match the reference code");

endmodule

`default_nettype wire

// >>> hdl/acs_top.sv
// Compare sequencer of the 8-bit compare-type converter, with its register port.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module acs_top
    import acs_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port.
    input wire acs_bus_req_t bus_req,
    output logic [ACS_DW-1:0] rdata,
    // Instruction cycle pulse and secondary resets from the core.
    input wire logic instr_tick,
    input wire acs_reset_evt_t rst_evt,
    // Comparator output, high when the input is above the reference.
    input wire logic cmp_in,
    // Pin control.
    output logic [ACS_NUM_TAPS-1:0] tap_sel,
    output logic [ACS_NUM_AIN-1:0] analog_sel,
    output logic [ACS_NUM_AIN-1:0] input_force,
    output logic [ACS_NUM_PD-1:0] pulldown_en
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and comparator synchroniser.
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic cmp_meta_reg;
    logic cmp_sync_reg;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            cmp_meta_reg <= 1'b0;
            cmp_sync_reg <= 1'b0;
        end
        else
        begin
            cmp_meta_reg <= cmp_in;
            cmp_sync_reg <= cmp_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode.
    acs_state_t state_reg;
    acs_state_t state_next;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic [7:0] ref_reg;
    logic [7:0] ref_next;
    logic [7:0] sar_bit_reg;
    logic [7:0] sar_bit_next;
    logic mode_reg;
    logic mode_next;
    logic status_reg;
    logic status_next;
    logic result_reg;
    logic result_next;
    logic [2:0] chan_reg;
    logic [ACS_NUM_PD-1:0] pd_reg;
    logic [ACS_DW-1:0] rd_mux;

    wire wr_chan = bus_req.wr && bus_req.addr == ACS_CHAN_SEL_OFS;
    wire wr_mode = bus_req.wr && bus_req.addr == ACS_MODE_SEL_OFS;
    wire wr_ref = bus_req.wr && bus_req.addr == ACS_REF_VAL_OFS;
    wire wr_pd = bus_req.wr && bus_req.addr == ACS_PULLDOWN_OFS;
    wire hold_evt = rst_evt.ce || rst_evt.clk_stop;
    wire any_evt = rst_evt.wdt_stack || hold_evt;
    wire [4:0] cnt_p1 = cnt_reg + 5'h01;
    wire sar_step = instr_tick && cnt_p1[0] && cnt_p1 >= ACS_HW_FIRST_STEP;
    wire chan_ok = bus_req.wdata[2:0] != ACS_CHAN_BAD;
    wire [ACS_NUM_AIN-1:0] sel_next = acs_chan_onehot(chan_reg);
    wire [ACS_DW-1:0] mode_view = {4'h0, 1'b0, mode_reg, status_reg, result_reg};

    assign rd_mux = (bus_req.addr == ACS_CHAN_SEL_OFS) ? {5'h00, chan_reg} :
                    (bus_req.addr == ACS_MODE_SEL_OFS) ? mode_view :
                    (bus_req.addr == ACS_REF_VAL_OFS) ? ref_reg :
                    (bus_req.addr == ACS_PULLDOWN_OFS) ? {4'h0, pd_reg} : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        ref_next = ref_reg;
        sar_bit_next = sar_bit_reg;
        mode_next = mode_reg;
        status_next = status_reg;
        result_next = result_reg;
        case (state_reg)
            ACS_SW_WAIT:
            begin
                if (instr_tick)
                begin
                    cnt_next = cnt_p1;
                    if (cnt_p1 == ACS_SW_DONE_TICKS)
                    begin
                        result_next = cmp_sync_reg;
                        state_next = ACS_IDLE;
                    end
                end
            end
            ACS_HW_RUN:
            begin
                if (instr_tick)
                begin
                    cnt_next = cnt_p1;
                end
                if (sar_step)
                begin
                    // Keep the trial bit only if the input is still above it.
                    ref_next = (cmp_sync_reg ? ref_reg : (ref_reg & ~sar_bit_reg)) |
                               (sar_bit_reg >> 1);
                    sar_bit_next = sar_bit_reg >> 1;
                    result_next = cmp_sync_reg;
                end
                if (instr_tick && cnt_p1 == ACS_HW_BUSY_TICKS)
                begin
                    status_next = 1'b0;
                end
                if (instr_tick && cnt_p1 == ACS_HW_DONE_TICKS)
                begin
                    state_next = ACS_IDLE;
                end
            end
            ACS_IDLE:
            begin
                cnt_next = cnt_reg;
            end
            default:
            begin
                state_next = ACS_IDLE;
            end
        endcase
        // A firmware reference write during hardware mode must not corrupt the search.
        if (wr_ref && state_reg != ACS_HW_RUN)
        begin
            ref_next = bus_req.wdata;
            if (!mode_reg)
            begin
                state_next = ACS_SW_WAIT;
                cnt_next = 5'h00;
            end
        end
        if (wr_mode)
        begin
            mode_next = bus_req.wdata[ACS_BIT_MODE];
            cnt_next = 5'h00;
            if (bus_req.wdata[ACS_BIT_MODE])
            begin
                state_next = ACS_HW_RUN;
                status_next = 1'b1;
                ref_next = ACS_SAR_SEED;
                sar_bit_next = ACS_SAR_SEED;
            end
            else
            begin
                state_next = ACS_IDLE;
                status_next = 1'b0;
            end
        end
        if (rst_evt.wdt_stack)
        begin
            state_next = ACS_IDLE;
            cnt_next = 5'h00;
            ref_next = ACS_REF_RESET;
            mode_next = 1'b0;
            status_next = 1'b0;
            result_next = 1'b0;
        end
        else if (hold_evt)
        begin
            state_next = ACS_IDLE;
            status_next = 1'b0;
            if (mode_reg)
            begin
                ref_next = ACS_REF_RESET;
            end
            if (rst_evt.ce)
            begin
                result_next = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            state_reg <= ACS_IDLE;
            cnt_reg <= 5'h00;
            ref_reg <= ACS_REF_RESET;
            sar_bit_reg <= ACS_SAR_SEED;
            mode_reg <= 1'b0;
            status_reg <= 1'b0;
            result_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            ref_reg <= ref_next;
            sar_bit_reg <= sar_bit_next;
            mode_reg <= mode_next;
            status_reg <= status_next;
            result_reg <= result_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin selection and pull-downs. CE reset and clock stop leave both alone.
    wire [2:0] chan_next = rst_evt.wdt_stack ? ACS_CHAN_NONE :
                           (wr_chan && chan_ok) ? bus_req.wdata[2:0] : chan_reg;
    wire [ACS_NUM_PD-1:0] pd_next = rst_evt.wdt_stack ? ACS_PULLDOWN_RESET :
                                    wr_pd ? bus_req.wdata[ACS_NUM_PD-1:0] : pd_reg;

    always_ff @(posedge core_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            chan_reg <= ACS_CHAN_NONE;
            pd_reg <= ACS_PULLDOWN_RESET;
            analog_sel <= '0;
            input_force <= '0;
            rdata <= 8'h00;
        end
        else
        begin
            chan_reg <= chan_next;
            pd_reg <= pd_next;
            analog_sel <= sel_next;
            input_force <= (|sel_next) ? ~sel_next : '0;
            rdata <= bus_req.rd ? rd_mux : 8'h00;
        end
    end

    // Firmware must clear the pull-down of the chosen port pin; it is not gated here.
    assign pulldown_en = pd_reg;

    acs_tap_decoder u_tap_decoder (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_reg),
        .ref_value(ref_reg),
        .tap_sel(tap_sel)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking acs_cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_sync_reg);

    wire quiet = !wr_mode && !wr_ref && !any_evt;

    chk_hw_start_sets: assert property (
        (wr_mode && bus_req.wdata[ACS_BIT_MODE] && !any_evt) |=>
        (status_reg && state_reg == ACS_HW_RUN && ref_reg == ACS_SAR_SEED))
        else $error("hardware start did not raise status");

    chk_status_drop_15: assert property (
        (state_reg == ACS_HW_RUN && instr_tick && cnt_p1 == ACS_HW_BUSY_TICKS && quiet) |=>
        (!status_reg && state_reg == ACS_HW_RUN))
        else $error("status not cleared at fifteenth cycle");

    chk_hw_done_17: assert property (
        (state_reg == ACS_HW_RUN && instr_tick && cnt_p1 == ACS_HW_DONE_TICKS && quiet) |=>
        (state_reg == ACS_IDLE && sar_bit_reg == 8'h00))
        else $error("conversion not complete at seventeenth cycle");

    chk_status_busy: assert property (
        status_reg |-> state_reg == ACS_HW_RUN)
        else $error("status high outside a conversion");

    chk_sw_result_3: assert property (
        (state_reg == ACS_SW_WAIT && instr_tick && cnt_p1 == ACS_SW_DONE_TICKS && quiet) |=>
        (result_reg == $past(cmp_sync_reg) && state_reg == ACS_IDLE))
        else $error("software result not latched at third cycle");

    chk_abort_mode: assert property (
        (wr_mode && !bus_req.wdata[ACS_BIT_MODE] && !any_evt) |=>
        (state_reg == ACS_IDLE && !status_reg) [*2])
        else $error("conversion not aborted");

    chk_sar_bit_drop: assert property (
        (state_reg == ACS_HW_RUN && sar_step && !cmp_sync_reg && quiet) |=>
        ((ref_reg & $past(sar_bit_reg)) == 8'h00))
        else $error("trial bit kept while input below reference");

    chk_chan_refused: assert property (
        (wr_chan && bus_req.wdata[2:0] == ACS_CHAN_BAD && !rst_evt.wdt_stack) |=>
        $stable(chan_reg))
        else $error("prohibited channel code accepted");

    chk_force_others: assert property (
        ((analog_sel & input_force) == '0) && $onehot0(analog_sel) &&
        (!(|analog_sel) || (input_force == ~analog_sel)))
        else $error("pin select and input forcing disagree");

    chk_mode_top_zero: assert property (
        (bus_req.rd && bus_req.addr == ACS_MODE_SEL_OFS) |=> !rdata[ACS_BIT_ZERO])
        else $error("mode register top bit read as one");

    chk_ref_hold_clear: assert property (
        (hold_evt && !rst_evt.wdt_stack && !bus_req.wr) |=>
        (ref_reg == ($past(mode_reg) ? ACS_REF_RESET : $past(ref_reg))))
        else $error("reference wrong after CE reset or clock stop");

    cov_sw_compare: cover property (
        state_reg == ACS_SW_WAIT ##1 state_reg == ACS_IDLE);
    cov_hw_complete: cover property (
        state_reg == ACS_HW_RUN && instr_tick && cnt_p1 == ACS_HW_DONE_TICKS);
    cov_hw_abort: cover property (
        state_reg == ACS_HW_RUN && status_reg && wr_mode && !bus_req.wdata[ACS_BIT_MODE]);

endmodule

`default_nettype wire

// >>> verif/acs_analog_model.sv
// Analog level on the selected pin as the comparator sees it against the tap.
`timescale 1ns/1ps
`default_nettype none

module acs_analog_model
    import acs_pkg::*;
(
    // Clock.
    input wire logic core_clk,
    // Selected tap and the pin level in half steps of one code.
    input wire logic [ACS_NUM_TAPS-1:0] tap_sel,
    input wire logic [8:0] vin_x2,
    // Slow settling delays the decision by one clock.
    input wire logic slow,
    // Comparator decision.
    output logic cmp_in
);
    logic [8:0] ref_x2;
    logic fast_cmp;
    logic slow_cmp;

    always_comb
    begin
        ref_x2 = '0;
        for (int i = 0; i < ACS_NUM_TAPS; i++)
        begin
            if (tap_sel[i])
            begin
                ref_x2 = 9'(i * 2);
            end
        end
    end

    // Odd half-step levels never equal a tap, so no tie is left to chance.
    assign fast_cmp = (vin_x2 > ref_x2);
    always_ff @(posedge core_clk)
    begin
        slow_cmp <= fast_cmp;
    end
    assign cmp_in = slow ? slow_cmp : fast_cmp;
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the converter compare sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end

module tb_top
    import acs_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n;
    acs_bus_req_t bus_req;
    logic [7:0] rdata;
    logic instr_tick = 1'b0;
    acs_reset_evt_t rst_evt;
    logic cmp_in;
    logic [ACS_NUM_TAPS-1:0] tap_sel;
    logic [5:0] analog_sel;
    logic [5:0] input_force;
    logic [3:0] pulldown_en;
    logic [8:0] vin_x2;
    logic slow;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    int tick_cnt = 0;

    acs_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
        .instr_tick(instr_tick), .rst_evt(rst_evt), .cmp_in(cmp_in), .tap_sel(tap_sel),
        .analog_sel(analog_sel), .input_force(input_force), .pulldown_en(pulldown_en));
    acs_analog_model i_pin (.core_clk(core_clk), .tap_sel(tap_sel), .vin_x2(vin_x2),
        .slow(slow), .cmp_in(cmp_in));

    ////////////////////////////////////////////////////////////////////////////
    initial forever #4 core_clk = ~core_clk;

    // Ticks six clocks apart leave room for the tap register and comparator sync.
    always @(posedge core_clk)
    begin
        tick_cnt <= (tick_cnt == 5) ? 0 : tick_cnt + 1;
        instr_tick <= (tick_cnt == 5);
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_total++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk);
        bus_req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n,
        input logic [7:0] m = 8'hff);
        @(posedge core_clk);
        bus_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk);
        bus_req <= '0;
        @(negedge core_clk);
        `CHK(n, e, rdata & m)
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge core_clk iff instr_tick);
    endtask

    task automatic settle();
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic evt(input acs_reset_evt_t e);
        @(posedge core_clk);
        rst_evt <= e;
        @(posedge core_clk);
        rst_evt <= '0;
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK("tap", ACS_TAP_ONE, tap_sel)
        `CHK("pd", 4'hf, pulldown_en)
        `CHK("sel", 6'h00, analog_sel)
        `CHK("frc", 6'h00, input_force)
        rd(8'h24, 8'h00, "chan");
        rd(8'h26, 8'h00, "ref");
        rd(8'h27, 8'h0f, "pdreg");
        rd(8'h30, 8'h00, "unmapped");
        wr(8'h25, 8'h0b);
        rd(8'h25, 8'h00, "mode");
    endtask

    task automatic t_chan();
        logic [5:0] s;
        wr(8'h27, 8'h0e);
        for (int c = 0; c < 7; c++)
        begin
            s = (c == 0) ? 6'h00 : 6'h01 << (c - 1);
            wr(8'h24, 8'(c));
            settle();
            `CHK("sel", s, analog_sel)
            `CHK("frc", (c == 0) ? 6'h00 : ~s, input_force)
        end
        wr(8'h24, 8'h07);
        rd(8'h24, 8'h06, "bad");
        wr(8'h24, 8'h01);
        rd(8'h27, 8'h0e, "pdreg");
        `CHK("pdpin", 4'he, pulldown_en)
    endtask

    // The flag must still show the previous outcome after two ticks.
    task automatic sw_cmp(input logic [7:0] r, input logic [8:0] v);
        logic e;
        e = (v > {r, 1'b0});
        vin_x2 <= v;
        ticks(1);
        wr(8'h26, r);
        settle();
        `CHK("tap", ACS_TAP_ONE << r, tap_sel)
        ticks(2);
        rd(8'h25, {7'h0, ~e}, "early");
        ticks(1);
        rd(8'h25, {7'h0, e}, "flag");
    endtask

    task automatic hw_conv(input logic [8:0] v);
        logic [7:0] r;
        r = v[8:1];
        vin_x2 <= v;
        ticks(1);
        wr(8'h25, 8'h04);
        rd(8'h26, 8'h80, "seed");
        rd(8'h25, 8'h06, "busy", 8'hfe);
        ticks(3);
        rd(8'h26, {r[7], 7'h40}, "step");
        // The read above ended after tick 4, so ten more ticks land on tick 14.
        ticks(10);
        rd(8'h25, 8'h06, "busy14", 8'hfe);
        ticks(1);
        rd(8'h25, 8'h04, "st15", 8'hfe);
        wr(8'h26, 8'h55);
        ticks(2);
        rd(8'h26, r, "result");
        rd(8'h25, {7'h02, r[0]}, "done");
    endtask

    task automatic t_abort(input logic [8:0] v);
        vin_x2 <= v;
        ticks(1);
        wr(8'h25, 8'h04);
        ticks(5);
        wr(8'h25, 8'h00);
        rd(8'h25, 8'h00, "abort", 8'hfe);
        ticks(4);
        rd(8'h26, {v[8:7], 6'h20}, "held");
    endtask

    task automatic t_events();
        ticks(1);
        wr(8'h25, 8'h04);
        ticks(4);
        evt(3'b010);
        rd(8'h26, 8'h00, "ce_ref");
        rd(8'h25, 8'h04, "ce_mode");
        rd(8'h24, 8'h01, "ce_chan");
        rd(8'h27, 8'h0e, "ce_pd");
        wr(8'h25, 8'h00);
        wr(8'h26, 8'h5a);
        evt(3'b001);
        rd(8'h26, 8'h5a, "stop_ref");
        evt(3'b100);
        rd(8'h26, 8'h00, "wdt_ref");
        rd(8'h24, 8'h00, "wdt_chan");
        settle();
        `CHK("wdt_pd", 4'hf, pulldown_en)
        `CHK("wdt_sel", 6'h00, analog_sel)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        bus_req <= '0;
        rst_evt <= '0;
        vin_x2 <= 9'h0ff;
        slow <= 1'b0;
        do_reset();
        t_reset();
        t_chan();
        sw_cmp(8'h7f, 9'h0ff);
        sw_cmp(8'h80, 9'h0ff);
        slow <= 1'b1;
        sw_cmp(8'h00, 9'h001);
        sw_cmp(8'hff, 9'h1fd);
        hw_conv(9'h001);
        hw_conv(9'h1ff);
        slow <= 1'b0;
        hw_conv(9'h0b7);
        hw_conv(9'h14b);
        t_abort(9'h14b);
        t_events();
        wr(8'h24, 8'h01);
        ticks(1);
        wr(8'h25, 8'h04);
        ticks(2);
        do_reset();
        rd(8'h25, 8'h00, "por_mode");
        rd(8'h26, 8'h00, "por_ref");
        rd(8'h24, 8'h00, "por_chan");
        test_done();
    end
endmodule
`default_nettype wire
